/* rtl/clock_source_config_defs.vh */
/*
 Constants for the clock source configuration block: register byte
 offsets, field positions, reset values and switch timing.
 Assumes inclusion by bare name from the block's design file.
*/
`ifndef CLOCK_SOURCE_CONFIG_DEFS_VH
`define CLOCK_SOURCE_CONFIG_DEFS_VH
// ------------------------------------------------------------
// register byte offsets, selector word indices and selector count
// ------------------------------------------------------------
`define OFS_KEY         8'h00
`define OFS_MOSC_TRIG   8'h04
`define OFS_MOSC_MASK   8'h08
`define OFS_HSI_MASK    8'h0c
`define OFS_PLL_TRIG    8'h10
`define OFS_PLL_MASK    8'h14
`define OFS_PLL_DIV     8'h18
`define OFS_AADC_DIV    8'h1c
`define OFS_SEL_BASE    8'h20
`define OFS_FOUT0_SEL   8'h48
`define OFS_FOUT0_DIV   8'h4c
`define OFS_FOUT1_SEL   8'h50
`define OFS_FOUT1_DIV   8'h54
`define OFS_GATE        8'h58
`define OFS_OPTION      8'h5c
`define OFS_OSC_STAT    8'h60
`define OFS_PORT_CFG    8'h64
`define OFS_FOUT_SYNC   8'h68
`define OFS_STAT_BASE   8'h80
`define SEL_IDX_BASE    4'd8
`define STAT_IDX_BASE   6'd32
`define SEL_COUNT       4'd10
`define SEL_CPU_IDX     9
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define KEY_UPPER       31'h52d2d280
`define START_BIT       0
`define STOP_BIT        1
`define SEL_RESET       30'h09249249
`define SEL_MASK        30'h092d9659
`define PLL_DIV_RESET   3'h1
`define AADC_DIV_RESET  1'b1
`define FOUT_SEL_RESET  3'h0
`define FOUT_DIV_RESET  10'h001
`define GATE_RESET      8'hff
`define PORT_CFG_RESET  5'h00
`define FREQ_BAD_BIT    2
// ------------------------------------------------------------
// timing and frequencies
// ------------------------------------------------------------
`define SWITCH_CYCLES   2'd2
`define HSI20_LAST      4'd9
`define MHZ_INTERNAL    10'd100
`define MHZ_M11_D1      10'd400
`define MHZ_M11_D2      10'd200
`define MHZ_M10_D1      10'd320
`define MHZ_M10_D2      10'd160
`define MHZ_M0X_D1      10'd240
`define MHZ_M0X_D2      10'd120
`endif

/* rtl/clock_source_config.v */
/*
 Clock source configuration: key-protected Wishbone register file,
 oscillator start/stop triggers, standby stop masks, option strap
 capture, dedicated clock selectors with status, module clock gates,
 two divided clock outputs and their pin function decode.
 Assumes oscillator clocks arrive as slow asynchronous levels and
 the standby and module reset requests come from the same clock.
*/
`include "clock_source_config_defs.vh"
`default_nettype none
module clock_source_config (
    input  wire        clock,
    input  wire        resetn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [2:0]  main_osc_freq_code,
    input  wire [1:0]  cpu_divider_mode,
    input  wire        chip_standby,
    input  wire [7:0]  module_reset_req,
    input  wire        main_osc_clock,
    input  wire        fast_internal_osc_clock,
    input  wire        slow_internal_osc_clock,
    input  wire        fast_peripheral_bus_clock,
    output reg         main_osc_enable,
    output reg         pll_enable,
    output reg         fast_osc_enable,
    output wire [29:0] selector_in_effect,
    output reg  [2:0]  pll_divider_code,
    output reg         async_converter_div1,
    output reg  [9:0]  cpu_freq_mhz,
    output reg  [7:0]  module_standby,
    output reg  [7:0]  module_clock_enable,
    output reg         lowpower_sampler_clock,
    output wire        clock_output_zero,
    output reg         clock_output_zero_oe,
    output wire        clock_output_one,
    output reg         clock_output_one_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg        key_enable_bit;
    reg        main_osc_run;
    reg        pll_run;
    reg        mosc_mask;
    reg        hsi_mask;
    reg        pll_mask;
    reg [2:0]  pll_div_reg;
    reg        aadc_div_reg;
    reg [29:0] sel_reg;
    reg [5:0]  fout_sel_reg;
    reg [19:0] fout_div_reg;
    reg [7:0]  gate_reg;
    reg [4:0]  port0_reg;
    reg [4:0]  port1_reg;
    reg [4:0]  strap_meta;
    reg [4:0]  strap_sync;
    reg [1:0]  opt_wait;
    reg [2:0]  freq_reg;
    reg [1:0]  mode_reg;
    reg [3:0]  src_meta;
    reg [3:0]  src_sync;
    reg        hsi_prev;
    reg [3:0]  hsi_cnt;
    reg        hsi20;
    reg [31:0] rd_cur;
    reg [9:0]  cpu_freq_next;
    wire [29:0] sel_stat;
    wire [1:0]  fout_sync;
    wire [1:0]  fout_pin;
    wire [3:0]  sel_idx;
    wire [3:0]  stat_idx;
    wire [31:0] lane_mask;
    wire [31:0] merged;
    wire        wr_go;
    wire        prot_ok;
    wire        hsi_on;
    wire [29:0] sel_mask_cur;
    localparam [29:0] SEL_RST = `SEL_RESET;

    assign sel_idx   = wb_adr_i[5:2] - `SEL_IDX_BASE;
    assign sel_mask_cur = `SEL_MASK >> (3*sel_idx);
    assign stat_idx  = wb_adr_i[5:2];
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign merged    = (rd_cur & ~lane_mask) | (wb_dat_i & lane_mask);
    assign wr_go     = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign prot_ok   = key_enable_bit;
    assign hsi_on    = ~chip_standby | hsi_mask;
    assign selector_in_effect = sel_stat;
    assign clock_output_zero  = fout_pin[0];
    assign clock_output_one   = fout_pin[1];

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @* begin
        rd_cur = 32'h0000_0000;
        case (wb_adr_i)
            `OFS_KEY:       rd_cur[0] = key_enable_bit;
            `OFS_MOSC_MASK: rd_cur[0] = mosc_mask;
            `OFS_HSI_MASK:  rd_cur[0] = hsi_mask;
            `OFS_PLL_MASK:  rd_cur[0] = pll_mask;
            `OFS_PLL_DIV:   rd_cur[2:0] = pll_div_reg;
            `OFS_AADC_DIV:  rd_cur[0] = aadc_div_reg;
            `OFS_FOUT0_SEL: rd_cur[2:0] = fout_sel_reg[2:0];
            `OFS_FOUT0_DIV: rd_cur[9:0] = fout_div_reg[9:0];
            `OFS_FOUT1_SEL: rd_cur[2:0] = fout_sel_reg[5:3];
            `OFS_FOUT1_DIV: rd_cur[9:0] = fout_div_reg[19:10];
            `OFS_GATE:      rd_cur[7:0] = gate_reg;
            `OFS_OPTION:    rd_cur = {mode_reg, 3'h0, freq_reg, 14'h0000, cpu_freq_mhz};
            `OFS_OSC_STAT:  rd_cur[2:0] = {fast_osc_enable, pll_enable, main_osc_enable};
            `OFS_PORT_CFG: begin
                rd_cur[12:8] = port1_reg;
                rd_cur[4:0]  = port0_reg;
                rd_cur[19:16] = {1'b0, port0_reg[4], port0_reg[3], port0_reg[2]} + 4'h1;
                rd_cur[27:24] = {1'b0, port1_reg[4], port1_reg[3], port1_reg[2]} + 4'h1;
            end
            `OFS_FOUT_SYNC: rd_cur[1:0] = fout_sync;
            default: begin
                if (wb_adr_i >= `OFS_SEL_BASE && sel_idx < `SEL_COUNT &&
                    wb_adr_i < `OFS_FOUT0_SEL)
                    rd_cur[2:0] = sel_reg[3*sel_idx +: 3];
                else if (wb_adr_i >= `OFS_STAT_BASE && stat_idx < `SEL_COUNT &&
                         wb_adr_i[7:6] == 2'b10)
                    rd_cur[2:0] = sel_stat[3*stat_idx +: 3];
            end
        endcase
    end

    // ------------------------------------------------------------
    // bus slave and register writes
    // ------------------------------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h0000_0000;
            key_enable_bit <= 1'b0;
            main_osc_run   <= 1'b0;
            pll_run        <= 1'b0;
            mosc_mask      <= 1'b0;
            hsi_mask       <= 1'b0;
            pll_mask       <= 1'b0;
            pll_div_reg    <= `PLL_DIV_RESET;
            aadc_div_reg   <= `AADC_DIV_RESET;
            sel_reg        <= `SEL_RESET;
            fout_sel_reg   <= {`FOUT_SEL_RESET, `FOUT_SEL_RESET};
            fout_div_reg   <= {`FOUT_DIV_RESET, `FOUT_DIV_RESET};
            gate_reg       <= `GATE_RESET;
            port0_reg      <= `PORT_CFG_RESET;
            port1_reg      <= `PORT_CFG_RESET;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= (wb_cyc_i & wb_stb_i & ~wb_ack_o) ? rd_cur : 32'h0000_0000;
            if (wr_go && wb_adr_i == `OFS_KEY && merged[31:1] == `KEY_UPPER)
                key_enable_bit <= merged[0];
            if (wr_go && prot_ok) begin
                case (wb_adr_i)
                    `OFS_MOSC_TRIG: begin
                        if (merged[`START_BIT] & ~merged[`STOP_BIT])
                            main_osc_run <= 1'b1;
                        else if (merged[`STOP_BIT] & ~merged[`START_BIT])
                            main_osc_run <= 1'b0;
                    end
                    `OFS_PLL_TRIG: begin
                        if (merged[`START_BIT] & ~merged[`STOP_BIT])
                            pll_run <= 1'b1;
                        else if (merged[`STOP_BIT] & ~merged[`START_BIT])
                            pll_run <= 1'b0;
                    end
                    `OFS_MOSC_MASK: mosc_mask    <= merged[0];
                    `OFS_HSI_MASK:  hsi_mask     <= merged[0];
                    `OFS_PLL_MASK:  pll_mask     <= merged[0];
                    `OFS_PLL_DIV:   pll_div_reg  <= merged[2:0];
                    `OFS_AADC_DIV:  aadc_div_reg <= merged[0];
                    `OFS_FOUT0_SEL: fout_sel_reg[2:0] <= merged[2:0];
                    `OFS_FOUT0_DIV: fout_div_reg[9:0] <= merged[9:0];
                    `OFS_FOUT1_SEL: fout_sel_reg[5:3] <= merged[2:0];
                    `OFS_FOUT1_DIV: fout_div_reg[19:10] <= merged[9:0];
                    `OFS_PORT_CFG: begin
                        port0_reg <= merged[4:0];
                        port1_reg <= merged[12:8];
                    end
                    default: begin
                        if (wb_adr_i >= `OFS_SEL_BASE && sel_idx < `SEL_COUNT &&
                            wb_adr_i < `OFS_FOUT0_SEL)
                            sel_reg[3*sel_idx +: 3] <= merged[2:0] &
                                sel_mask_cur[2:0];
                    end
                endcase
            end
            // module reset wins over a clearing write in the same cycle
            if (wr_go && prot_ok && wb_adr_i == `OFS_GATE)
                gate_reg <= merged[7:0] | module_reset_req;
            else
                gate_reg <= gate_reg | module_reset_req;
        end
    end

    // ------------------------------------------------------------
    // oscillator enables, gates, straps, cpu frequency
    // ------------------------------------------------------------
    always @* begin
        cpu_freq_next = 10'd0;
        if (sel_stat[3*`SEL_CPU_IDX])
            cpu_freq_next = `MHZ_INTERNAL;
        else begin
            case ({mode_reg, pll_div_reg})
                5'b11_001: cpu_freq_next = `MHZ_M11_D1;
                5'b11_010: cpu_freq_next = `MHZ_M11_D2;
                5'b10_001: cpu_freq_next = `MHZ_M10_D1;
                5'b10_010: cpu_freq_next = `MHZ_M10_D2;
                5'b00_001: cpu_freq_next = `MHZ_M0X_D1;
                5'b00_010: cpu_freq_next = `MHZ_M0X_D2;
                5'b01_001: cpu_freq_next = `MHZ_M0X_D1;
                5'b01_010: cpu_freq_next = `MHZ_M0X_D2;
                default:   cpu_freq_next = 10'd0;
            endcase
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            main_osc_enable        <= 1'b0;
            pll_enable             <= 1'b0;
            fast_osc_enable        <= 1'b1;
            pll_divider_code       <= `PLL_DIV_RESET;
            async_converter_div1   <= `AADC_DIV_RESET;
            cpu_freq_mhz           <= 10'd0;
            module_standby         <= `GATE_RESET;
            module_clock_enable    <= 8'h00;
            clock_output_zero_oe   <= 1'b0;
            clock_output_one_oe    <= 1'b0;
            strap_meta             <= 5'h00;
            strap_sync             <= 5'h00;
            opt_wait               <= 2'd0;
            freq_reg               <= 3'h0;
            mode_reg               <= 2'h0;
            src_meta               <= 4'h0;
            src_sync               <= 4'h0;
            hsi_prev               <= 1'b0;
            hsi_cnt                <= 4'h0;
            hsi20                  <= 1'b0;
            lowpower_sampler_clock <= 1'b0;
        end else begin
            main_osc_enable      <= main_osc_run & (~chip_standby | mosc_mask);
            pll_enable           <= pll_run & (~chip_standby | pll_mask);
            fast_osc_enable      <= hsi_on;
            pll_divider_code     <= pll_div_reg;
            async_converter_div1 <= aadc_div_reg;
            cpu_freq_mhz         <= cpu_freq_next;
            module_standby       <= gate_reg;
            module_clock_enable  <= ~gate_reg;
            clock_output_zero_oe <= port0_reg[0] & ~port0_reg[1];
            clock_output_one_oe  <= port1_reg[0] & ~port1_reg[1];
            strap_meta <= {cpu_divider_mode, main_osc_freq_code};
            strap_sync <= strap_meta;
            if (opt_wait != 2'd3)
                opt_wait <= opt_wait + 2'd1;
            if (opt_wait == 2'd2) begin
                freq_reg <= strap_sync[2:0];
                mode_reg <= strap_sync[4:3];
            end
            src_meta <= {fast_internal_osc_clock, slow_internal_osc_clock,
                         fast_peripheral_bus_clock, main_osc_clock};
            src_sync <= src_meta;
            hsi_prev <= src_sync[3];
            if (src_sync[3] & ~hsi_prev) begin
                if (hsi_cnt == `HSI20_LAST) begin
                    hsi_cnt <= 4'h0;
                    hsi20   <= ~hsi20;
                end else
                    hsi_cnt <= hsi_cnt + 4'h1;
            end
            lowpower_sampler_clock <= hsi_on ? hsi20 : src_sync[2];
        end
    end

    // ------------------------------------------------------------
    // selector status: follows after the switch settles
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 10; i = i + 1) begin : g_sel
            reg [2:0] stat_reg;
            reg [1:0] wait_reg;
            assign sel_stat[3*i +: 3] = stat_reg;
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    stat_reg <= SEL_RST[3*i +: 3];
                    wait_reg <= 2'd0;
                end else if (sel_reg[3*i +: 3] != stat_reg) begin
                    if (wait_reg == 2'd0)
                        wait_reg <= `SWITCH_CYCLES;
                    else if (wait_reg == 2'd1) begin
                        stat_reg <= sel_reg[3*i +: 3];
                        wait_reg <= 2'd0;
                    end else
                        wait_reg <= wait_reg - 2'd1;
                end else
                    wait_reg <= 2'd0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // clock outputs: source pick and divide
    // ------------------------------------------------------------
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_fout
            reg [9:0] cnt_reg;
            reg [9:0] ratio_reg;
            reg [2:0] src_reg;
            reg       prev_reg;
            reg       out_reg;
            reg       lvl;
            assign fout_pin[i]  = out_reg;
            assign fout_sync[i] = (ratio_reg == fout_div_reg[10*i +: 10]) &&
                                  (src_reg == fout_sel_reg[3*i +: 3]);
            always @* begin
                case (src_reg)
                    3'b001:  lvl = src_sync[1];
                    3'b011:  lvl = src_sync[2];
                    3'b100:  lvl = hsi20;
                    3'b010:  lvl = 1'b0;
                    3'b101:  lvl = 1'b0;
                    default: lvl = src_sync[0];
                endcase
            end
            // new source and ratio are taken only at a period boundary
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    cnt_reg   <= 10'd0;
                    ratio_reg <= `FOUT_DIV_RESET;
                    src_reg   <= `FOUT_SEL_RESET;
                    prev_reg  <= 1'b0;
                    out_reg   <= 1'b0;
                end else begin
                    prev_reg <= lvl;
                    if (lvl & ~prev_reg) begin
                        if (ratio_reg == 10'd0 || cnt_reg >= ratio_reg - 10'd1) begin
                            cnt_reg   <= 10'd0;
                            ratio_reg <= fout_div_reg[10*i +: 10];
                            src_reg   <= fout_sel_reg[3*i +: 3];
                        end else
                            cnt_reg <= cnt_reg + 10'd1;
                    end
                    if (ratio_reg == 10'd1)
                        out_reg <= lvl;
                    else
                        out_reg <= (ratio_reg != 10'd0) &&
                                   (cnt_reg < {1'b0, ratio_reg[9:1]});
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* tb/clock_source_config_props.sv */
/*
 Port checker for the clock source configuration block, bound to it.
 Assumes the block's defs header is on the include path.
*/
`include "clock_source_config_defs.vh"
`default_nettype none
module clock_source_config_props (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        chip_standby,
    input wire logic [7:0]  module_reset_req,
    input wire logic        fast_osc_enable,
    input wire logic [29:0] selector_in_effect,
    input wire logic [2:0]  pll_divider_code,
    input wire logic [9:0]  cpu_freq_mhz,
    input wire logic [7:0]  module_standby
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // key state seen from committed writes
    // ------------------------------------------------------------
    logic key_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            key_q <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == `OFS_KEY && wb_dat_i[31:1] == `KEY_UPPER)
            key_q <= wb_dat_i[0];
    end
    sequence req_open;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence locked_div_write;
        wb_ack_o && wb_we_i && wb_adr_i == `OFS_PLL_DIV && !key_q;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_TAKEN: assert property (req_open |=> wb_ack_o)
        else $error("request not answered in one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_KEY_BLOCK: assert property (locked_div_write |-> ##2 $stable(pll_divider_code))
        else $error("locked write changed pll divider");
    AST_SEL_LATENCY: assert property ($changed(selector_in_effect) |->
        $past(wb_ack_o && wb_we_i, 4))
        else $error("selector status moved off its write timing");
    AST_CPU_INT: assert property (
        selector_in_effect[27] && resetn |=> cpu_freq_mhz == `MHZ_INTERNAL)
        else $error("cpu clock not internal when selected");
    AST_GATE_SET: assert property (module_reset_req[0] |-> ##[1:2] module_standby[0])
        else $error("module reset did not stop module");
    AST_FOSC_RUN: assert property (!chip_standby [*3] |-> fast_osc_enable)
        else $error("fast oscillator off outside standby");
    AST_CPU_SET: assert property (
        cpu_freq_mhz inside {10'd0, 10'd100, 10'd400, 10'd200, 10'd320, 10'd160, 10'd240, 10'd120})
        else $error("cpu frequency outside table");
endmodule
bind clock_source_config clock_source_config_props u_props (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chip_standby(chip_standby), .module_reset_req(module_reset_req),
    .fast_osc_enable(fast_osc_enable), .selector_in_effect(selector_in_effect),
    .pll_divider_code(pll_divider_code), .cpu_freq_mhz(cpu_freq_mhz),
    .module_standby(module_standby));
`default_nettype wire

/* tb/testbench.sv */
/*
 Self-checking bench for the clock source configuration block.
 Assumes the design, its defs header and the checker are compiled too.
*/
`include "clock_source_config_defs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, resetn, cyc, stb, we, stby, ack, oe0, mosc_en, pll_en, fosc_en;
    logic        oe1, co0, p;
    logic [7:0]  adr, mrst, mstby, mce;
    logic [31:0] dat, rdat, rnd, cfg;
    logic [3:0]  sel, osc;
    logic [2:0]  freq, m;
    logic [1:0]  mode;
    logic [9:0]  mhz;
    logic [29:0] sie;
    int          mismatches, checked, cycles, n;
    logic [31:0] expq[$];
    clock_source_config uut (
        .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .main_osc_freq_code(freq), .cpu_divider_mode(mode), .chip_standby(stby),
        .module_reset_req(mrst), .main_osc_clock(osc[0]), .fast_internal_osc_clock(osc[1]),
        .slow_internal_osc_clock(osc[3]), .fast_peripheral_bus_clock(osc[2]),
        .main_osc_enable(mosc_en), .pll_enable(pll_en), .fast_osc_enable(fosc_en),
        .selector_in_effect(sie), .pll_divider_code(), .async_converter_div1(),
        .cpu_freq_mhz(mhz), .module_standby(mstby), .module_clock_enable(mce),
        .lowpower_sampler_clock(), .clock_output_zero(co0), .clock_output_zero_oe(oe0),
        .clock_output_one(), .clock_output_one_oe(oe1));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge clock);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
        do @(posedge clock); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 32'h0, 1'b0);
    endtask
    // ------------------------------------------------------------
    // read checker and timeout
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cycles++;
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
            chk("read data", expq.pop_front(), rdat);
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    always @(posedge clock) osc <= osc + 4'h1;
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, cyc, stb, we, stby, adr, mrst, dat, sel, osc, freq} = '0;
        mode = 2'b11;
        rnd = 32'h18ffc63f;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        chk("standby", 32'hff, {24'h0, mstby});
        rd(`OFS_GATE, 32'hff);
        for (int i = 0; i < 10; i++) rd(`OFS_STAT_BASE + 8'(4 * i), 32'h1);
        wr(`OFS_PLL_DIV, 32'h2);
        rd(`OFS_PLL_DIV, 32'h1);
        $display("reset and lock test done");
        wr(`OFS_KEY, 32'ha5a5a501);
        rd(`OFS_KEY, 32'h1);
        wr(`OFS_SEL_BASE + 8'd36, 32'h0);
        for (int c = 2; c > 0; c--) begin
            wr(`OFS_PLL_DIV, c);
            repeat (6) @(posedge clock);
            chk("cpu mhz", (c == 1) ? 32'd400 : 32'd200, {22'h0, mhz});
        end
        for (int k = 0; k < 2; k++) begin
            wr(k ? `OFS_PLL_TRIG : `OFS_MOSC_TRIG, 32'h1);
            repeat (2) @(posedge clock);
            chk("osc run", 32'h1, {31'h0, k ? pll_en : mosc_en});
            wr(k ? `OFS_PLL_TRIG : `OFS_MOSC_TRIG, 32'h2);
            repeat (2) @(posedge clock);
            chk("osc run", 32'h0, {31'h0, k ? pll_en : mosc_en});
        end
        stby <= 1'b1;
        repeat (4) @(posedge clock);
        chk("fast osc", 32'h0, {31'h0, fosc_en});
        wr(`OFS_HSI_MASK, 32'h1);
        repeat (4) @(posedge clock);
        chk("fast osc", 32'h1, {31'h0, fosc_en});
        stby <= 1'b0;
        $display("oscillator test done");
        for (int i = 0; i < 9; i++) begin
            rnd = lfsr(rnd);
            m = 3'(`SEL_MASK >> (3 * i));
            wr(`OFS_SEL_BASE + 8'(4 * i), rnd);
            repeat (4) @(posedge clock);
            chk("slot", {29'h0, m & rnd[2:0]}, {29'h0, sie[3 * i +: 3]});
            rd(`OFS_STAT_BASE + 8'(4 * i), {29'h0, m & rnd[2:0]});
        end
        $display("selector test done");
        wr(`OFS_GATE, 32'h0);
        repeat (2) @(posedge clock);
        chk("standby", 32'h0, {24'h0, mstby});
        chk("clock enable", 32'hff, {24'h0, mce});
        mrst <= 8'h01;
        @(posedge clock);
        mrst <= 8'h00;
        repeat (2) @(posedge clock);
        chk("standby", 32'h1, {24'h0, mstby});
        chk("clock enable", 32'hfe, {24'h0, mce});
        for (int c = 0; c < 9; c++) begin
            cfg = (c == 8) ? 32'h3 : {27'h0, 3'(c), 2'b01};
            wr(`OFS_PORT_CFG, cfg | (cfg << 8));
            repeat (2) @(posedge clock);
            chk("pin oe", {30'h0, {2{c != 8}}}, {30'h0, oe1, oe0});
            m = (c == 8) ? 3'h0 : 3'(c);
            rd(`OFS_PORT_CFG, cfg | (cfg << 8) | ({29'h0, m} + 32'h1) * 32'h01010000);
        end
        rd(8'hfc, 32'h0);
        $display("gate, port and map test done");
        rd(`OFS_FOUT_SYNC, 32'h3);
        wr(`OFS_FOUT0_DIV, 32'h2);
        repeat (8) @(posedge clock);
        rd(`OFS_FOUT_SYNC, 32'h3);
        n = 0;
        repeat (40) begin
            p = co0;
            @(posedge clock);
            n += int'(co0 & ~p);
        end
        chk("clock out", 32'd10, n);
        $display("clock output test done");
        repeat (3) @(posedge clock);
        end_sim();
    end
endmodule
`default_nettype wire
